// ### src/timer_irq_pkg.sv
// Constants, field positions and carrier types for the timer and serial control block
package timer_irq_pkg;

    // Register offsets on the internal data bus
    localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h09;
    localparam logic [7:0] OFF_MISC_IRQ_CONTROL = 8'h0A;
    localparam logic [7:0] OFF_SERIAL_CONTROL = 8'h10;
    localparam logic [7:0] OFF_SERIAL_STATUS = 8'h11;
    localparam logic [7:0] OFF_SERIAL_SHIFT_DATA = 8'h12;

    // timer_control fields
    localparam int TC_FLAG = 7;
    localparam int TC_MASK = 6;
    localparam int TC_SRC_HI = 5;
    localparam int TC_SRC_LO = 4;
    localparam int TC_PRE_CLR = 3;
    localparam int TC_RATIO_HI = 2;

    // Count source encodings
    localparam logic [1:0] SRC_BUS_CLK = 2'h0;
    localparam logic [1:0] SRC_GATED = 2'h1;
    localparam logic [1:0] SRC_STOPPED = 2'h2;
    localparam logic [1:0] SRC_PIN_EVENT = 2'h3;

    // misc_irq_control fields
    localparam int MISC_FLAG = 7;
    localparam int MISC_MASK = 6;

    // serial_control fields
    localparam int SC_TX_EN = 7;
    localparam int SC_RX_EN = 6;
    localparam int SC_CLK_HI = 5;
    localparam int SC_CLK_LO = 4;
    localparam int SC_RATE_HI = 3;
    localparam logic [1:0] SCLK_INTERNAL = 2'h2;
    localparam logic [1:0] SCLK_EXTERNAL = 2'h3;

    // serial_status fields
    localparam int SS_DONE = 7;
    localparam int SS_PERIODIC = 6;
    localparam int SS_DONE_MASK = 5;
    localparam int SS_PERIODIC_MASK = 4;
    localparam int SS_PRE_CLR = 3;

    // Reset values
    localparam logic [7:0] TIMER_CONTROL_RST = 8'h0050;
    localparam logic [7:0] TIMER_COUNT_RST = 8'h00FF;
    localparam logic [6:0] TIMER_PRE_RST = 7'h007F;
    localparam logic [6:0] TIMER_PRE_FULL = 7'h007F;
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h0000;
    localparam logic [7:0] SHIFT_DATA_RST = 8'h0000;
    localparam logic [14:0] XFER_PRE_RST = 15'h0000;
    localparam logic [14:0] XFER_PRE_FULL = 15'h7FFF;

    // Transfer clock: one bus cycle at rate code 0, doubling per step
    localparam int XFER_PRE_W = 15;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } bus_req_t;

    typedef enum logic [1:0] {VEC_NONE, VEC_TIMER, VEC_SERIAL} irq_vec_t;

    typedef struct packed {
        logic tx_pin_enable;
        logic rx_pin_enable;
        logic clk_pin_out_enable;
        logic clk_pin_in_enable;
    } pin_route_t;

endpackage : timer_irq_pkg

// ### src/timer_serial_irq_control.sv
// Timer, second external interrupt and serial control/status registers with request logic
// How it works
// - Global CPU mask holds every pending request; cleared mask presents them by priority.
// - Individual masks: misc bit 6, timer control bit 6, status bits 5 and 4.
// - Pin levels are readable for branch tests without touching edge latches.
// - Falling edge on second external pin sets misc bit 7.
// - Software may clear misc bit 7 but writing one does nothing.
// - Reset clears misc request flag and sets its mask.
// - Counter loads from software, decrements per prescaled tick, flags at zero.
// - From zero the counter wraps to all ones and keeps counting.
// - Reading the count returns it without disturbing counting.
// - Timer control bits 5:4 pick bus clock, gated, stopped or pin events.
// - Reset sets prescaler and counter to ones, clears flag, sets mask.
// - Reset selects gated source at divide-by-one; high pin counts at once.
// - Writing one to timer control bit 3 restarts prescaler; reads zero.
// - Timer control bits 2:0 give divide by two to the field value.
// - Timer request flag stays set until software writes zero.
// - Serial control bits 7 and 6 claim transmit and receive pins.
// - Serial control bits 5:4 choose port, internal clock out, external in.
// - Serial control bits 3:0 pick sixteen doubling transfer periods.
// - Done flag sets per transfer; clears on reset, zero write, data access while serial control bit 5 is set.
// - Periodic flag sets on each transfer clock fall; clears on zero write.
// - Status bits 5 and 4 are read/write masks, set by reset.
// - Writing one to status bit 3 restarts transfer prescaler; reads zero.
// - Serial and periodic share a vector; second external shares the timer one.
// - Data register access with internal clock restarts the transfer prescaler.
`timescale 1ns/1ps
`default_nettype none

module timer_serial_irq_control (
    input wire logic clk,
    input wire logic rst,
    input wire timer_irq_pkg::bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic cpu_irq_mask,
    output logic irq_req,
    output timer_irq_pkg::irq_vec_t irq_vec,
    input wire logic int_pin_n,
    input wire logic second_external_irq_pin_n,
    input wire logic timer_pin,
    output logic int_level,
    output logic second_external_irq_level,
    input wire logic xfer_done,
    input wire logic [7:0] xfer_rx_data,
    output logic [7:0] shift_data,
    output logic shift_restart,
    output timer_irq_pkg::pin_route_t pin_route,
    output logic xfer_clk_out
);
    import timer_irq_pkg::*;

    // Pin synchronisers: int, second_external_irq, timer
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            // Timer pin idles low, interrupt pins idle high
            pin_s1_r <= 3'h3;
            pin_s2_r <= 3'h3;
            pin_s3_r <= 3'h3;
        end else begin
            pin_s1_r <= {timer_pin, second_external_irq_pin_n, int_pin_n};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    logic second_external_irq_fall;
    logic timer_level;
    logic timer_rise;
    assign second_external_irq_fall = pin_s3_r[1] & ~pin_s2_r[1];
    assign timer_level = pin_s2_r[2];
    assign timer_rise = timer_level & ~pin_s3_r[2];

    // Branch test levels, separate from the edge latch
    assign int_level = pin_s2_r[0];
    assign second_external_irq_level = pin_s2_r[1];

    // Bus decode
    logic sel_cnt, sel_tc, sel_misc, sel_sc, sel_ss, sel_sd;
    assign sel_cnt = bus_req.addr == OFF_TIMER_COUNT;
    assign sel_tc = bus_req.addr == OFF_TIMER_CONTROL;
    assign sel_misc = bus_req.addr == OFF_MISC_IRQ_CONTROL;
    assign sel_sc = bus_req.addr == OFF_SERIAL_CONTROL;
    assign sel_ss = bus_req.addr == OFF_SERIAL_STATUS;
    assign sel_sd = bus_req.addr == OFF_SERIAL_SHIFT_DATA;

    logic wr_cnt, wr_tc, wr_misc, wr_sc, wr_ss, sd_access;
    assign wr_cnt = bus_req.wr & sel_cnt;
    assign wr_tc = bus_req.wr & sel_tc;
    assign wr_misc = bus_req.wr & sel_misc;
    assign wr_sc = bus_req.wr & sel_sc;
    assign wr_ss = bus_req.wr & sel_ss;
    assign sd_access = (bus_req.wr | bus_req.rd) & sel_sd;

    // Timer control
    logic [7:0] tc_r;
    logic tmr_zero;
    logic pre_clr;
    assign pre_clr = wr_tc & bus_req.wdata[TC_PRE_CLR];

    always_ff @(posedge clk) begin
        if (rst) begin
            tc_r <= TIMER_CONTROL_RST;
        end else begin
            tc_r[TC_FLAG] <= tmr_zero | (tc_r[TC_FLAG] & ~(wr_tc & ~bus_req.wdata[TC_FLAG]));
            if (wr_tc) begin
                tc_r[TC_MASK:TC_SRC_LO] <= bus_req.wdata[TC_MASK:TC_SRC_LO];
                tc_r[TC_RATIO_HI:0] <= bus_req.wdata[TC_RATIO_HI:0];
            end
            tc_r[TC_PRE_CLR] <= 1'b0;
        end
    end

    // Count source select
    logic src_tick;
    always_comb begin
        case (tc_r[TC_SRC_HI:TC_SRC_LO])
            SRC_BUS_CLK: src_tick = 1'b1;
            SRC_GATED: src_tick = timer_level;
            SRC_STOPPED: src_tick = 1'b0;
            SRC_PIN_EVENT: src_tick = timer_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // Prescaler counts down; counter steps when low ratio bits are zero
    logic [6:0] pre_r;
    logic [6:0] pre_mask;
    logic tmr_dec;
    assign pre_mask = TIMER_PRE_FULL >> (3'd7 - tc_r[TC_RATIO_HI:0]);
    assign tmr_dec = src_tick & ((pre_r & pre_mask) == 7'h00);

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_r <= TIMER_PRE_RST;
        end else if (pre_clr) begin
            pre_r <= TIMER_PRE_RST;
        end else if (src_tick) begin
            pre_r <= pre_r - 7'h01;
        end
    end

    logic [7:0] cnt_r;
    assign tmr_zero = tmr_dec & ~wr_cnt & (cnt_r == 8'h01);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= TIMER_COUNT_RST;
        end else if (wr_cnt) begin
            cnt_r <= bus_req.wdata;
        end else if (tmr_dec) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // Second external interrupt
    logic misc_flag_r;
    logic misc_mask_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            misc_flag_r <= 1'b0;
            misc_mask_r <= 1'b1;
        end else begin
            misc_flag_r <= second_external_irq_fall | (misc_flag_r & ~(wr_misc & ~bus_req.wdata[MISC_FLAG]));
            if (wr_misc) begin
                misc_mask_r <= bus_req.wdata[MISC_MASK];
            end
        end
    end

    // Serial control
    logic [7:0] sc_r;
    logic [1:0] sclk_sel;
    logic [3:0] rate_sel;
    assign sclk_sel = sc_r[SC_CLK_HI:SC_CLK_LO];
    assign rate_sel = sc_r[SC_RATE_HI:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            sc_r <= SERIAL_CONTROL_RST;
        end else if (wr_sc) begin
            sc_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_route <= '0;
        end else begin
            pin_route.tx_pin_enable <= sc_r[SC_TX_EN];
            pin_route.rx_pin_enable <= sc_r[SC_RX_EN];
            pin_route.clk_pin_out_enable <= sclk_sel == SCLK_INTERNAL;
            pin_route.clk_pin_in_enable <= sclk_sel == SCLK_EXTERNAL;
        end
    end

    // Transfer clock generator
    logic [14:0] xpre_r;
    logic [14:0] xmask;
    logic xpre_clr;
    logic xfer_fall;
    assign xmask = XFER_PRE_FULL >> (4'd15 - rate_sel);
    assign xfer_fall = (xpre_r & xmask) == xmask;
    assign xpre_clr = (wr_ss & bus_req.wdata[SS_PRE_CLR]) | (sd_access & (sclk_sel == SCLK_INTERNAL));

    always_ff @(posedge clk) begin
        if (rst) begin
            xpre_r <= XFER_PRE_RST;
        end else if (xpre_clr) begin
            xpre_r <= XFER_PRE_RST;
        end else begin
            xpre_r <= xpre_r + 15'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_clk_out <= 1'b1;
        end else if (rate_sel == 4'h0) begin
            xfer_clk_out <= 1'b1;
        end else begin
            xfer_clk_out <= xpre_r[4'(rate_sel - 4'h1)];
        end
    end

    // Serial status
    logic done_r, per_r, done_mask_r, per_mask_r;
    logic done_clr;
    assign done_clr = (wr_ss & ~bus_req.wdata[SS_DONE]) | (sd_access & sc_r[SC_CLK_HI]);

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            done_r <= xfer_done | (done_r & ~done_clr);
            per_r <= xfer_fall | (per_r & ~(wr_ss & ~bus_req.wdata[SS_PERIODIC]));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_mask_r <= 1'b1;
            per_mask_r <= 1'b1;
        end else if (wr_ss) begin
            done_mask_r <= bus_req.wdata[SS_DONE_MASK];
            per_mask_r <= bus_req.wdata[SS_PERIODIC_MASK];
        end
    end

    // Shift data register
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_data <= SHIFT_DATA_RST;
            shift_restart <= 1'b0;
        end else begin
            shift_restart <= sd_access;
            if (bus_req.wr & sel_sd) begin
                shift_data <= bus_req.wdata;
            end else if (xfer_done) begin
                shift_data <= xfer_rx_data;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (!bus_req.rd) begin
            bus_rdata <= 8'h00;
        end else if (sel_cnt) begin
            bus_rdata <= cnt_r;
        end else if (sel_tc) begin
            bus_rdata <= {tc_r[TC_FLAG:TC_SRC_LO], 1'b0, tc_r[TC_RATIO_HI:0]};
        end else if (sel_misc) begin
            bus_rdata <= {misc_flag_r, misc_mask_r, 6'h00};
        end else if (sel_sc) begin
            bus_rdata <= sc_r;
        end else if (sel_ss) begin
            bus_rdata <= {done_r, per_r, done_mask_r, per_mask_r, 4'h0};
        end else if (sel_sd) begin
            bus_rdata <= shift_data;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Request presentation
    logic tmr_vec_req;
    logic ser_vec_req;
    assign tmr_vec_req = (tc_r[TC_FLAG] & ~tc_r[TC_MASK]) | (misc_flag_r & ~misc_mask_r);
    assign ser_vec_req = (done_r & ~done_mask_r) | (per_r & ~per_mask_r);

    always_comb begin
        irq_req = ~cpu_irq_mask & (tmr_vec_req | ser_vec_req);
        if (cpu_irq_mask) begin
            irq_vec = VEC_NONE;
        end else if (tmr_vec_req) begin
            irq_vec = VEC_TIMER;
        end else if (ser_vec_req) begin
            irq_vec = VEC_SERIAL;
        end else begin
            irq_vec = VEC_NONE;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence second_external_irq_edge_seq;
        pin_s3_r[1] && !pin_s2_r[1];
    endsequence

    sequence last_count_seq;
        tmr_dec && !wr_cnt && cnt_r == 8'h01;
    endsequence

    AST_MASK_HOLDS: assert property (cpu_irq_mask |-> !irq_req && irq_vec == VEC_NONE)
        else $error("Request presented while global mask set");
    AST_TIMER_FIRST: assert property (!cpu_irq_mask && tmr_vec_req |-> irq_req && irq_vec == VEC_TIMER)
        else $error("Timer vector not preferred");
    AST_SECOND_EXTERNAL_IRQ_EDGE: assert property (second_external_irq_edge_seq |=> misc_flag_r)
        else $error("Edge did not raise misc flag");
    AST_MISC_NO_SET: assert property (wr_misc && !misc_flag_r && !second_external_irq_fall |=> !misc_flag_r)
        else $error("Software raised misc flag");
    AST_ZERO_FLAG: assert property (last_count_seq |=> cnt_r == 8'h00 && tc_r[TC_FLAG])
        else $error("Zero count did not flag");
    AST_WRAP: assert property (tmr_dec && !wr_cnt && cnt_r == 8'h00 |=> cnt_r == 8'hFF)
        else $error("Counter did not wrap");
    AST_STOPPED: assert property (tc_r[TC_SRC_HI:TC_SRC_LO] == SRC_STOPPED && !wr_cnt |=> $stable(cnt_r))
        else $error("Counter moved while stopped");
    AST_PRE_RESTART: assert property (pre_clr |=> pre_r == TIMER_PRE_RST && !tc_r[TC_PRE_CLR])
        else $error("Prescaler not restarted");
    AST_FLAG_STAYS: assert property (tc_r[TC_FLAG] && !wr_tc |=> tc_r[TC_FLAG])
        else $error("Timer flag dropped without write");
    AST_DONE_SET_WINS: assert property (xfer_done && done_clr |=> done_r)
        else $error("Done event lost to clear");
    AST_SD_CLEARS: assert property (sd_access && sc_r[SC_CLK_HI] && !xfer_done |=> !done_r)
        else $error("Data access did not clear done");
    AST_PERIODIC: assert property (xfer_fall |=> per_r)
        else $error("Periodic flag not set");
    AST_SD_RESTART: assert property (sd_access && sclk_sel == SCLK_INTERNAL |=> xpre_r == XFER_PRE_RST)
        else $error("Transfer prescaler not restarted");

    // Reset image of the control state
    logic reset_state_ok;
    assign reset_state_ok = tc_r == TIMER_CONTROL_RST && cnt_r == TIMER_COUNT_RST && pre_r == TIMER_PRE_RST
        && !misc_flag_r && misc_mask_r && sc_r == SERIAL_CONTROL_RST && !done_r && !per_r
        && done_mask_r && per_mask_r && xfer_clk_out && bus_rdata == 8'h00;

    sequence xfer_wrap_seq;
        xfer_fall && rate_sel != 4'h0 && !wr_sc;
    endsequence

    sequence gate_closed_seq;
        tc_r[TC_SRC_HI:TC_SRC_LO] == SRC_GATED && !timer_level && !wr_cnt;
    endsequence

    AST_RESET_STATE: assert property (disable iff (1'b0) rst |=> reset_state_ok)
        else $error("Register left reset with wrong value");
    AST_CLK_FALL: assert property (xfer_wrap_seq |-> ##2 !xfer_clk_out)
        else $error("Transfer clock did not fall with periodic flag");
    AST_GATED_LOW: assert property (gate_closed_seq |=> $stable(cnt_r))
        else $error("Counter moved while gate closed");
    AST_COUNT_READ: assert property (bus_req.rd && sel_cnt |=> bus_rdata == $past(cnt_r))
        else $error("Count read returned wrong value");
    AST_TC_BIT3_ZERO: assert property (bus_req.rd && sel_tc |=> !bus_rdata[TC_PRE_CLR])
        else $error("Timer control bit 3 read as one");
    AST_SS_LOW_ZERO: assert property (bus_req.rd && sel_ss |=> bus_rdata[SS_PRE_CLR:0] == 4'h0)
        else $error("Status low bits read as nonzero");
    AST_TIMER_CLEAR: assert property (wr_tc && !bus_req.wdata[TC_FLAG] && !tmr_zero |=> !tc_r[TC_FLAG])
        else $error("Timer flag not cleared by zero write");
    AST_MISC_CLEAR: assert property (wr_misc && !bus_req.wdata[MISC_FLAG] && !second_external_irq_fall |=> !misc_flag_r)
        else $error("Misc flag not cleared by zero write");
    AST_PER_CLEAR: assert property (wr_ss && !bus_req.wdata[SS_PERIODIC] && !xfer_fall |=> !per_r)
        else $error("Periodic flag not cleared by zero write");
    AST_MASKS_BLOCK: assert property (tc_r[TC_MASK] && misc_mask_r && done_mask_r && per_mask_r |-> !irq_req)
        else $error("Masked request reached the CPU");
    AST_SERIAL_VEC: assert property (!cpu_irq_mask && !tmr_vec_req && ser_vec_req |-> irq_vec == VEC_SERIAL)
        else $error("Serial vector not presented");

endmodule : timer_serial_irq_control
`default_nettype wire

// ### tb/ext_peer.sv
// Timer input source and serial peer model for the far side
`timescale 1ns/1ps
`default_nettype none

module ext_peer (
    input wire logic clk,
    input wire logic idle_level,
    input wire logic go,
    input wire logic [7:0] events,
    input wire logic send,
    input wire logic [7:0] send_byte,
    input wire logic [3:0] delay,
    output logic timer_pin,
    output logic xfer_done,
    output logic [7:0] xfer_rx_data
);
    initial begin
        timer_pin = 1'b0;
        xfer_done = 1'b0;
        xfer_rx_data = 8'h00;
    end

    // Pin events, two cycles high then two low
    always @(posedge clk) begin
        if (go) begin
            for (int i = 0; i < events; i++) begin
                timer_pin <= 1'b1;
                repeat (2) @(posedge clk);
                timer_pin <= 1'b0;
                repeat (2) @(posedge clk);
            end
        end else begin
            timer_pin <= idle_level;
        end
    end

    // Completion after a chosen delay; data inverts every cycle outside it
    always @(posedge clk) begin
        if (send) begin
            repeat (delay) @(posedge clk);
            xfer_done <= 1'b1;
            xfer_rx_data <= send_byte;
        end else begin
            xfer_done <= 1'b0;
            xfer_rx_data <= ~xfer_rx_data;
        end
    end
endmodule : ext_peer
`default_nettype wire

// ### tb/timer_serial_irq_control_test.sv
// Self-checking bench for the timer, interrupt and serial control block
`timescale 1ns/1ps
`default_nettype none

module timer_serial_irq_control_test;
    import timer_irq_pkg::*;
    logic clk, rst, cpu_irq_mask, irq_req, int_pin_n, second_external_irq_pin_n, timer_pin, int_level, second_external_irq_level;
    logic xfer_done, shift_restart, xfer_clk_out, go, send, idle_level;
    logic [7:0] bus_rdata, xfer_rx_data, shift_data, events, send_byte, v, a, timer_control, misc, serial_status;
    logic [3:0] delay;
    bus_req_t bus_req;
    irq_vec_t irq_vec;
    pin_route_t pin_route;
    int failures, check_count, seed;

    timer_serial_irq_control dut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .irq_vec(irq_vec), .int_pin_n(int_pin_n),
        .second_external_irq_pin_n(second_external_irq_pin_n), .timer_pin(timer_pin), .int_level(int_level), .second_external_irq_level(second_external_irq_level),
        .xfer_done(xfer_done), .xfer_rx_data(xfer_rx_data), .shift_data(shift_data),
        .shift_restart(shift_restart), .pin_route(pin_route), .xfer_clk_out(xfer_clk_out));
    ext_peer peer (.clk(clk), .idle_level(idle_level), .go(go), .events(events), .send(send),
        .send_byte(send_byte), .delay(delay), .timer_pin(timer_pin), .xfer_done(xfer_done),
        .xfer_rx_data(xfer_rx_data));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Register write with the model's access rules
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        case (ad)
            OFF_TIMER_CONTROL: timer_control = (timer_control & d & 8'h80) | (d & 8'h77);
            OFF_MISC_IRQ_CONTROL: misc = (misc & d & 8'h80) | (d & 8'h40);
            OFF_SERIAL_STATUS: serial_status = (serial_status & d & 8'hC0) | (d & 8'h30);
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [7:0] q);
        @(posedge clk);
        bus_req <= '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 q = bus_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] q;
        rd(ad, q);
        chk(q & m, exp & m);
    endtask : rdc

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        seed = 90;
        failures = 0;
        check_count = 0;
        rst = 1'b1;
        cpu_irq_mask = 1'b1;
        int_pin_n = 1'b1;
        second_external_irq_pin_n = 1'b1;
        bus_req = '0;
        go = 1'b0;
        send = 1'b0;
        idle_level = 1'b0;
        events = 8'h00;
        send_byte = 8'h00;
        delay = 4'h0;
        timer_control = 8'h50;
        misc = 8'h40;
        serial_status = 8'h30;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(OFF_TIMER_CONTROL, 8'hFF, timer_control);
        rdc(OFF_TIMER_COUNT, 8'hFF, 8'hFF);
        rdc(OFF_MISC_IRQ_CONTROL, 8'hFF, misc);
        rdc(OFF_SERIAL_CONTROL, 8'hFF, 8'h00);
        rdc(OFF_SERIAL_STATUS, 8'hBF, serial_status);
        rdc(8'h20, 8'hFF, 8'h00);
        chk({7'h0, xfer_clk_out}, 8'h01);
        chk({7'h0, irq_req}, 8'h00);
        // Gated source
        @(posedge clk);
        idle_level <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFF_TIMER_COUNT, a);
        repeat (6) @(posedge clk);
        rd(OFF_TIMER_COUNT, v);
        chk(a - v, 8'h08);
        @(posedge clk);
        idle_level <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFF_TIMER_COUNT, a);
        repeat (6) @(posedge clk);
        rdc(OFF_TIMER_COUNT, 8'hFF, a);
        // Every prescaler ratio, then stopped and pin event sources
        for (int r = 0; r < 8; r++) begin
            wr(OFF_TIMER_CONTROL, 8'h40 | 8'(r));
            wr(OFF_TIMER_COUNT, 8'h80 | 8'($random(seed) & 63));
            rd(OFF_TIMER_COUNT, a);
            repeat ((4 << r) - 2) @(posedge clk);
            rd(OFF_TIMER_COUNT, v);
            chk(a - v, 8'h04);
        end
        wr(OFF_TIMER_CONTROL, 8'h60);
        rd(OFF_TIMER_COUNT, a);
        repeat (20) @(posedge clk);
        rdc(OFF_TIMER_COUNT, 8'hFF, a);
        wr(OFF_TIMER_CONTROL, 8'h70);
        wr(OFF_TIMER_COUNT, 8'h50);
        events <= 8'h05;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (26) @(posedge clk);
        rdc(OFF_TIMER_COUNT, 8'hFF, 8'h4B);
        // Expiry, wrap and flag handling
        wr(OFF_TIMER_CONTROL, 8'h00);
        wr(OFF_TIMER_COUNT, 8'h02);
        repeat (4) @(posedge clk);
        timer_control = timer_control | 8'h80;
        rdc(OFF_TIMER_CONTROL, 8'hFF, timer_control);
        chk({7'h0, irq_req}, 8'h00);
        rd(OFF_TIMER_COUNT, v);
        chk(8'(v > 8'hF0), 8'h01);
        @(posedge clk);
        cpu_irq_mask <= 1'b0;
        @(posedge clk);
        #1 chk({7'h0, irq_req}, 8'h01);
        chk({6'h0, irq_vec}, {6'h0, VEC_TIMER});
        wr(OFF_TIMER_CONTROL, 8'hA8);
        rdc(OFF_TIMER_CONTROL, 8'hFF, timer_control);
        wr(OFF_TIMER_CONTROL, 8'h60);
        rdc(OFF_TIMER_CONTROL, 8'hFF, timer_control);
        chk({7'h0, irq_req}, 8'h00);
        // Second external interrupt
        wr(OFF_MISC_IRQ_CONTROL, 8'h80);
        rdc(OFF_MISC_IRQ_CONTROL, 8'hFF, misc);
        @(posedge clk);
        int_pin_n <= 1'b0;
        second_external_irq_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({6'h0, int_level, second_external_irq_level}, 8'h00);
        misc = misc | 8'h80;
        rdc(OFF_MISC_IRQ_CONTROL, 8'hFF, misc);
        chk({6'h0, irq_vec}, {6'h0, VEC_TIMER});
        wr(OFF_MISC_IRQ_CONTROL, 8'h40);
        rdc(OFF_MISC_IRQ_CONTROL, 8'hFF, misc);
        chk({7'h0, irq_req}, 8'h00);
        @(posedge clk);
        int_pin_n <= 1'b1;
        second_external_irq_pin_n <= 1'b1;
        // Serial pin routing and clock choice
        for (int i = 0; i < 4; i++) begin
            v = i[1] ? (i[0] ? 8'hF3 : 8'hA0) : (i[0] ? 8'h40 : 8'h80);
            wr(OFF_SERIAL_CONTROL, v);
            rdc(OFF_SERIAL_CONTROL, 8'hFF, v);
            chk({4'h0, pin_route}, {4'h0, v[7], v[6], v[5] & ~v[4], v[5] & v[4]});
        end
        // Transfer completion
        wr(OFF_SERIAL_STATUS, 8'h10);
        send_byte <= 8'($random(seed));
        delay <= 4'($random(seed) & 3);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (6) @(posedge clk);
        serial_status = serial_status | 8'h80;
        rdc(OFF_SERIAL_STATUS, 8'h80, serial_status);
        chk({6'h0, irq_vec}, {6'h0, VEC_SERIAL});
        rd(OFF_SERIAL_SHIFT_DATA, v);
        chk(v, send_byte);
        chk({7'h0, shift_restart}, 8'h01);
        serial_status = serial_status & 8'h7F;
        rdc(OFF_SERIAL_STATUS, 8'h80, serial_status);
        chk(shift_data, send_byte);
        // Periodic request from the transfer clock
        wr(OFF_SERIAL_CONTROL, 8'hF4);
        wr(OFF_SERIAL_STATUS, 8'h0F);
        wr(OFF_SERIAL_STATUS, 8'h08);
        rdc(OFF_SERIAL_STATUS, 8'hFF, serial_status);
        repeat (16) @(posedge clk);
        serial_status = serial_status | 8'h40;
        rdc(OFF_SERIAL_STATUS, 8'hFF, serial_status);
        chk({6'h0, irq_vec}, {6'h0, VEC_SERIAL});
        wr(OFF_SERIAL_STATUS, 8'h10);
        #1 chk({7'h0, irq_req}, 8'h00);
        print_verdict();
    end
endmodule : timer_serial_irq_control_test
`default_nettype wire
